/* lro_pkg.sv */
// Shared constants and types for the line interface reset and register block
package lro_pkg;

    localparam int NUM_CH = 8;
    localparam int NUM_IRQ_GRP = 5;

    // Address decode: upper byte 00 holds the global registers and channel 0; upper bytes 00..07 select channel 0..7
    localparam logic [7:0] GLB_UPPER = 8'h00;
    localparam logic [7:0] GCM_OFF = 8'h00;
    localparam logic [7:0] MASK_BASE_OFF = 8'h08;
    localparam logic [7:0] ISR_BASE_OFF = 8'h10;
    localparam logic [7:0] CH_CTRL_OFF = 8'h20;
    localparam logic [7:0] CH_STAT_OFF = 8'h21;

    // Field positions
    localparam int VFE_BIT = 4;
    localparam int GLB_T1_BIT = 0;
    localparam int CH_T1_BIT = 0;
    localparam int PLL_LSB = 5;
    localparam int PLL_W = 11;
    localparam int SER_ADDR_W = 6;

    // Values after reset
    localparam logic [7:0] GCM_RST = 8'h10;
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] CH_CTRL_RST = 8'h00;
    localparam logic [7:0] ISR_RST = 8'h00;

    // Host interface strap codes
    localparam logic [1:0] IF_INTEL = 2'h0;
    localparam logic [1:0] IF_MOTOROLA = 2'h1;
    localparam logic [1:0] IF_SPI = 2'h2;
    localparam logic [1:0] IF_VSCI = 2'h3;

    // Timing
    localparam int MCLK_KHZ = 25000;
    localparam int RESET_MIN_US = 10;
    localparam int RESET_CYC = (RESET_MIN_US * MCLK_KHZ + 999) / 1000;
    localparam int RST_CNT_W = 9;

    typedef logic [7:0] lro_byte_t;

endpackage

/* lro_if.sv */
// Pin-level carrier between the line interface device and its host controller
`timescale 1ns/1ps
interface lro_if;
    logic chip_reset_n;
    logic compat;
    logic [1:0] host_if_select;
    logic [15:0] addr;
    logic [15:0] host_d;
    logic host_d_oe;
    logic [15:0] dev_d;
    logic dev_d_oe;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic ble_n;
    logic bhe_n;
    logic irq_n;

    modport device (
        input chip_reset_n, compat, host_if_select, addr, host_d, host_d_oe,
        input cs_n, rd_n, wr_n, ble_n, bhe_n,
        output dev_d, dev_d_oe, irq_n
    );

    modport host (
        output chip_reset_n, compat, host_if_select, addr, host_d, host_d_oe,
        output cs_n, rd_n, wr_n, ble_n, bhe_n,
        input dev_d, dev_d_oe, irq_n
    );
endinterface

/* lro_host.sv */
// Host controller end: reset sequence with straps, then parallel register accesses
`timescale 1ns/1ps
module lro_host
    import lro_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    lro_if.host pins,
    input wire logic [1:0] cfg_if_select,
    input wire logic [SER_ADDR_W-1:0] cfg_serial_addr,
    input wire logic [PLL_W-1:0] cfg_pll,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [1:0] cmd_be,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [15:0] rsp_rdata,
    output logic irq_pending
);

    typedef enum logic [1:0] {H_RESET, H_IDLE, H_ACCESS, H_WAIT} lro_hstate_t;

    lro_hstate_t state_r, state_nxt;
    logic [RST_CNT_W-1:0] cnt_r, cnt_nxt;
    logic rst_n_r, rst_n_nxt;
    logic [1:0] sel_r, sel_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [15:0] d_r, d_nxt;
    logic d_oe_r, d_oe_nxt;
    logic cs_n_r, cs_n_nxt;
    logic rd_n_r, rd_n_nxt;
    logic wr_n_r, wr_n_nxt;
    logic ble_n_r, ble_n_nxt;
    logic bhe_n_r, bhe_n_nxt;
    logic ready_r, ready_nxt;
    logic rsp_valid_r, rsp_valid_nxt;
    logic [15:0] rsp_r, rsp_nxt;
    logic irq_r, irq_nxt;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rst_n_nxt = rst_n_r;
        sel_nxt = sel_r;
        addr_nxt = addr_r;
        d_nxt = d_r;
        d_oe_nxt = d_oe_r;
        cs_n_nxt = 1'b1;
        rd_n_nxt = 1'b1;
        wr_n_nxt = 1'b1;
        ble_n_nxt = 1'b1;
        bhe_n_nxt = 1'b1;
        ready_nxt = 1'b0;
        rsp_valid_nxt = 1'b0;
        rsp_nxt = rsp_r;
        irq_nxt = !pins.irq_n;
        unique case (state_r)
            H_RESET:
            begin
                // Straps stay on the pins until the release edge
                rst_n_nxt = 1'b0;
                sel_nxt = cfg_if_select;
                addr_nxt = 16'h0000;
                if (cfg_if_select == IF_VSCI)
                begin
                    addr_nxt[SER_ADDR_W-1:0] = cfg_serial_addr;
                end
                d_nxt = 16'h0000;
                d_oe_nxt = cfg_if_select[1];
                if (cfg_if_select[1])
                begin
                    d_nxt[15:PLL_LSB] = cfg_pll;
                end
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == RST_CNT_W'(RESET_CYC - 1))
                begin
                    // Config may only be trusted once reset is released
                    rst_n_nxt = 1'b1;
                    d_oe_nxt = 1'b0;
                    addr_nxt = 16'h0000;
                    state_nxt = H_IDLE;
                    ready_nxt = 1'b1;
                end
            end
            H_IDLE:
            begin
                ready_nxt = 1'b1;
                if (cmd_valid && ready_r)
                begin
                    ready_nxt = 1'b0;
                    addr_nxt = cmd_addr;
                    d_nxt = cmd_wdata;
                    d_oe_nxt = cmd_write;
                    cs_n_nxt = 1'b0;
                    ble_n_nxt = !cmd_be[0];
                    bhe_n_nxt = !cmd_be[1];
                    if (sel_r == IF_MOTOROLA)
                    begin
                        rd_n_nxt = 1'b0;
                        wr_n_nxt = !cmd_write;
                    end
                    else
                    begin
                        rd_n_nxt = cmd_write;
                        wr_n_nxt = !cmd_write;
                    end
                    state_nxt = H_ACCESS;
                end
            end
            H_ACCESS:
            begin
                d_oe_nxt = 1'b0;
                state_nxt = H_WAIT;
            end
            H_WAIT:
            begin
                rsp_valid_nxt = 1'b1;
                rsp_nxt = pins.dev_d_oe ? pins.dev_d : 16'h0000;
                ready_nxt = 1'b1;
                state_nxt = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= H_RESET;
            cnt_r <= '0;
            rst_n_r <= 1'b0;
            sel_r <= IF_INTEL;
            addr_r <= 16'h0000;
            d_r <= 16'h0000;
            d_oe_r <= 1'b0;
            cs_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            ble_n_r <= 1'b1;
            bhe_n_r <= 1'b1;
            ready_r <= 1'b0;
            rsp_valid_r <= 1'b0;
            rsp_r <= 16'h0000;
            irq_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rst_n_r <= rst_n_nxt;
            sel_r <= sel_nxt;
            addr_r <= addr_nxt;
            d_r <= d_nxt;
            d_oe_r <= d_oe_nxt;
            cs_n_r <= cs_n_nxt;
            rd_n_r <= rd_n_nxt;
            wr_n_r <= wr_n_nxt;
            ble_n_r <= ble_n_nxt;
            bhe_n_r <= bhe_n_nxt;
            ready_r <= ready_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign pins.chip_reset_n = rst_n_r;
    assign pins.compat = 1'b0;
    assign pins.host_if_select = sel_r;
    assign pins.addr = addr_r;
    assign pins.host_d = d_r;
    assign pins.host_d_oe = d_oe_r;
    assign pins.cs_n = cs_n_r;
    assign pins.rd_n = rd_n_r;
    assign pins.wr_n = wr_n_r;
    assign pins.ble_n = ble_n_r;
    assign pins.bhe_n = bhe_n_r;
    assign cmd_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_rdata = rsp_r;
    assign irq_pending = irq_r;

endmodule

/* lro_device.sv */
// Device end: strap capture, global and per-channel registers, interrupt pin
`timescale 1ns/1ps
module lro_device
    import lro_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    lro_if.device pins,
    input wire logic [NUM_IRQ_GRP-1:0][NUM_CH-1:0] irq_event,
    input wire logic [NUM_CH-1:0][7:0] alarm_status,
    output logic [1:0] host_if_mode,
    output logic [SER_ADDR_W-1:0] serial_src_addr,
    output logic [PLL_W-1:0] pll_config,
    output logic [NUM_CH-1:0] ch_t1_mode,
    output logic variable_freq_enable
);

    // Configuration and interrupt state
    lro_byte_t gcm_r, gcm_nxt;
    lro_byte_t mask_r [NUM_IRQ_GRP];
    lro_byte_t mask_nxt [NUM_IRQ_GRP];
    lro_byte_t isr_r [NUM_IRQ_GRP];
    lro_byte_t isr_nxt [NUM_IRQ_GRP];
    lro_byte_t ch_ctrl_r [NUM_CH];
    lro_byte_t ch_ctrl_nxt [NUM_CH];

    // Straps and pin-side outputs
    logic [1:0] sel_r, sel_nxt;
    logic [SER_ADDR_W-1:0] saddr_r, saddr_nxt;
    logic [PLL_W-1:0] pll_r, pll_nxt;
    logic [15:0] dout_r, dout_nxt;
    logic doe_r, doe_nxt;
    logic irq_n_r, irq_n_nxt;
    logic [NUM_CH-1:0] t1_r, t1_nxt;

    logic rd_req;
    logic wr_req;
    logic [15:0] lane_addr [2];
    logic [1:0] lane_en;
    logic [7:0] wdata [2];

    // Register read mux for one byte address
    function automatic lro_byte_t rd_byte(input logic [15:0] a, input lro_byte_t g,
                                          input lro_byte_t m [NUM_IRQ_GRP],
                                          input lro_byte_t s [NUM_IRQ_GRP],
                                          input lro_byte_t c [NUM_CH],
                                          input logic [NUM_CH-1:0][7:0] st);
        lro_byte_t v;
        v = 8'h00;
        if (a[15:8] == GLB_UPPER)
        begin
            if (a[7:0] == GCM_OFF)
            begin
                v = g;
            end
            for (int k = 0; k < NUM_IRQ_GRP; k++)
            begin
                if (a[7:0] == MASK_BASE_OFF + 8'(k))
                begin
                    v = m[k];
                end
                if (a[7:0] == ISR_BASE_OFF + 8'(k))
                begin
                    v = s[k];
                end
            end
        end
        if (a[15:8] < 8'(NUM_CH))
        begin
            if (a[7:0] == CH_CTRL_OFF)
            begin
                v = c[a[10:8]];
            end
            if (a[7:0] == CH_STAT_OFF)
            begin
                v = st[a[10:8]];
            end
        end
        return v;
    endfunction

    // Bus decode; serial modes leave the parallel port deaf
    always_comb
    begin
        rd_req = 1'b0;
        wr_req = 1'b0;
        if (pins.chip_reset_n && !pins.cs_n && !sel_r[1])
        begin
            if (sel_r == IF_MOTOROLA)
            begin
                rd_req = !pins.rd_n && pins.wr_n;
                wr_req = !pins.rd_n && !pins.wr_n;
            end
            else
            begin
                rd_req = !pins.rd_n;
                wr_req = !pins.wr_n;
            end
        end
        // Even lane is the low byte, odd lane the high byte
        lane_addr[0] = {pins.addr[15:1], 1'b0};
        lane_addr[1] = {pins.addr[15:1], 1'b1};
        lane_en = {!pins.bhe_n, !pins.ble_n};
        wdata[0] = pins.host_d[7:0];
        wdata[1] = pins.host_d[15:8];
    end

    always_comb
    begin
        gcm_nxt = gcm_r;
        mask_nxt = mask_r;
        ch_ctrl_nxt = ch_ctrl_r;
        sel_nxt = sel_r;
        saddr_nxt = saddr_r;
        pll_nxt = pll_r;
        dout_nxt = 16'h0000;
        doe_nxt = 1'b0;
        for (int k = 0; k < NUM_IRQ_GRP; k++)
        begin
            isr_nxt[k] = isr_r[k] | irq_event[k];
        end
        for (int l = 0; l < 2; l++)
        begin
            if (rd_req && lane_en[l])
            begin
                if (l == 0)
                begin
                    dout_nxt[7:0] = rd_byte(lane_addr[l], gcm_r, mask_r, isr_r, ch_ctrl_r,
                                            alarm_status);
                end
                else
                begin
                    dout_nxt[15:8] = rd_byte(lane_addr[l], gcm_r, mask_r, isr_r, ch_ctrl_r,
                                             alarm_status);
                end
                doe_nxt = 1'b1;
                for (int k = 0; k < NUM_IRQ_GRP; k++)
                begin
                    // New events in the read cycle survive the clear
                    if (lane_addr[l] == {GLB_UPPER, ISR_BASE_OFF + 8'(k)})
                    begin
                        isr_nxt[k] = irq_event[k];
                    end
                end
            end
            if (wr_req && lane_en[l])
            begin
                if (lane_addr[l] == {GLB_UPPER, GCM_OFF})
                begin
                    gcm_nxt = wdata[l];
                end
                for (int k = 0; k < NUM_IRQ_GRP; k++)
                begin
                    if (lane_addr[l] == {GLB_UPPER, MASK_BASE_OFF + 8'(k)})
                    begin
                        mask_nxt[k] = wdata[l];
                    end
                end
                if (lane_addr[l][15:8] < 8'(NUM_CH) && lane_addr[l][7:0] == CH_CTRL_OFF)
                begin
                    ch_ctrl_nxt[lane_addr[l][10:8]] = wdata[l];
                end
            end
        end
        // Chip reset pin: defaults reloaded, straps tracked until release
        if (!pins.chip_reset_n)
        begin
            gcm_nxt = GCM_RST;
            for (int k = 0; k < NUM_IRQ_GRP; k++)
            begin
                mask_nxt[k] = MASK_RST;
                isr_nxt[k] = ISR_RST;
            end
            for (int c = 0; c < NUM_CH; c++)
            begin
                ch_ctrl_nxt[c] = CH_CTRL_RST;
            end
            sel_nxt = pins.host_if_select;
            saddr_nxt = (pins.host_if_select == IF_VSCI) ? pins.addr[SER_ADDR_W-1:0] : '0;
            pll_nxt = pins.host_if_select[1] ? pins.host_d[15:PLL_LSB] : '0;
        end
        // A set mask bit hides its source from the pin
        irq_n_nxt = 1'b1;
        for (int k = 0; k < NUM_IRQ_GRP; k++)
        begin
            if (|(isr_r[k] & ~mask_r[k]))
            begin
                irq_n_nxt = 1'b0;
            end
        end
        for (int c = 0; c < NUM_CH; c++)
        begin
            if (gcm_r[VFE_BIT])
            begin
                t1_nxt[c] = ch_ctrl_r[c][CH_T1_BIT];
            end
            else
            begin
                t1_nxt[c] = gcm_r[GLB_T1_BIT];
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            gcm_r <= GCM_RST;
            for (int k = 0; k < NUM_IRQ_GRP; k++)
            begin
                mask_r[k] <= MASK_RST;
                isr_r[k] <= ISR_RST;
            end
            for (int c = 0; c < NUM_CH; c++)
            begin
                ch_ctrl_r[c] <= CH_CTRL_RST;
            end
            sel_r <= IF_INTEL;
            saddr_r <= '0;
            pll_r <= '0;
            dout_r <= 16'h0000;
            doe_r <= 1'b0;
            irq_n_r <= 1'b1;
            t1_r <= '0;
        end
        else
        begin
            gcm_r <= gcm_nxt;
            mask_r <= mask_nxt;
            isr_r <= isr_nxt;
            ch_ctrl_r <= ch_ctrl_nxt;
            sel_r <= sel_nxt;
            saddr_r <= saddr_nxt;
            pll_r <= pll_nxt;
            dout_r <= dout_nxt;
            doe_r <= doe_nxt;
            irq_n_r <= irq_n_nxt;
            t1_r <= t1_nxt;
        end
    end

    assign pins.dev_d = dout_r;
    assign pins.dev_d_oe = doe_r;
    assign pins.irq_n = irq_n_r;
    assign host_if_mode = sel_r;
    assign serial_src_addr = saddr_r;
    assign pll_config = pll_r;
    assign ch_t1_mode = t1_r;
    assign variable_freq_enable = gcm_r[VFE_BIT];

endmodule

/* lro_props.sv */
// Interface checker for the reset and register carrier
`timescale 1ns/1ps
module lro_props
    import lro_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic chip_reset_n,
    input wire logic compat,
    input wire logic [1:0] host_if_select,
    input wire logic host_d_oe,
    input wire logic dev_d_oe,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic irq_n
);
    logic [RST_CNT_W-1:0] low_cnt_r;
    logic [RST_CNT_W-1:0] low_cnt_nxt;

    // Saturates so a very long reset never wraps to a short count
    always_comb
    begin
        low_cnt_nxt = low_cnt_r;
        if (chip_reset_n)
            low_cnt_nxt = '0;
        else if (low_cnt_r != '1)
            low_cnt_nxt = low_cnt_r + 1'b1;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            low_cnt_r <= '0;
        else
            low_cnt_r <= low_cnt_nxt;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_reset_low_len: assert property ($rose(chip_reset_n) |-> low_cnt_r >= RESET_CYC)
        else $error("reset pin released too early");
    a_compat_held_low: assert property (!chip_reset_n |-> !compat)
        else $error("compat strap high during reset");
    a_strap_stable: assert property (chip_reset_n |-> $stable(host_if_select))
        else $error("interface strap moved after reset");
    a_pll_strap_driven: assert property (
        $rose(chip_reset_n) && host_if_select[1] |-> $past(host_d_oe))
        else $error("pll strap not driven at reset release");
    a_read_answered: assert property (
        chip_reset_n && !host_if_select[1] && !cs_n && !rd_n && wr_n |=> dev_d_oe)
        else $error("parallel read not answered");
    a_answer_has_cause: assert property (
        dev_d_oe |-> !$past(cs_n) && !$past(rd_n) && $past(wr_n))
        else $error("read data without a read strobe");
    a_write_silent: assert property (chip_reset_n && !cs_n && !wr_n |=> !dev_d_oe)
        else $error("write produced read data");
    a_reset_refuses: assert property (!chip_reset_n |=> !dev_d_oe)
        else $error("device answered during reset");
    a_serial_refuses: assert property (host_if_select[1] |=> !dev_d_oe)
        else $error("parallel bus answered in serial mode");
    a_irq_masked_reset: assert property (!chip_reset_n [*3] |-> irq_n)
        else $error("interrupt pin active after reset");
endmodule

/* lro_tb_top.sv */
// Testbench joining host and device ends over the pin carrier
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, (e), (g)); end end
module lro_tb_top
    import lro_pkg::*;
();
    logic mclk;
    logic arst_n;
    logic [1:0] cfg_sel;
    logic [SER_ADDR_W-1:0] cfg_sa;
    logic [PLL_W-1:0] cfg_pll;
    logic cmd_valid, cmd_write, cmd_ready, rsp_valid, irq_pending;
    logic [15:0] cmd_addr, cmd_wdata, rsp_rdata, q;
    logic [1:0] cmd_be;
    logic [NUM_IRQ_GRP-1:0][NUM_CH-1:0] irq_event;
    logic [NUM_CH-1:0][7:0] alarm_status;
    logic [1:0] host_if_mode;
    logic [SER_ADDR_W-1:0] serial_src_addr;
    logic [PLL_W-1:0] pll_config;
    logic [NUM_CH-1:0] ch_t1_mode;
    logic variable_freq_enable;
    int error_cnt = 0;
    int checks = 0;

    lro_if lro_if_inst ();

    lro_host lro_host_inst (.mclk(mclk), .arst_n(arst_n), .pins(lro_if_inst.host),
        .cfg_if_select(cfg_sel), .cfg_serial_addr(cfg_sa), .cfg_pll(cfg_pll),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_be(cmd_be), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_pending(irq_pending));

    lro_device lro_device_inst (.mclk(mclk), .arst_n(arst_n), .pins(lro_if_inst.device),
        .irq_event(irq_event), .alarm_status(alarm_status), .host_if_mode(host_if_mode),
        .serial_src_addr(serial_src_addr), .pll_config(pll_config),
        .ch_t1_mode(ch_t1_mode), .variable_freq_enable(variable_freq_enable));

    lro_props lro_props_inst (.mclk(mclk), .arst_n(arst_n),
        .chip_reset_n(lro_if_inst.chip_reset_n), .compat(lro_if_inst.compat),
        .host_if_select(lro_if_inst.host_if_select), .host_d_oe(lro_if_inst.host_d_oe),
        .dev_d_oe(lro_if_inst.dev_d_oe), .cs_n(lro_if_inst.cs_n), .rd_n(lro_if_inst.rd_n),
        .wr_n(lro_if_inst.wr_n), .irq_n(lro_if_inst.irq_n));

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Entered and left at a falling edge, so one request never overlaps the next
    task automatic do_cmd(input logic w, input logic [15:0] a, input logic [15:0] d,
        input logic [1:0] be);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_addr = a;
        cmd_wdata = d;
        cmd_be = be;
        @(negedge mclk);
        cmd_valid = 1'b0;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        if (n == 10)
            error_cnt++;
        q = rsp_rdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        do_cmd(1'b1, a, d, be);
        repeat (2) @(negedge mclk);
    endtask

    // Only enabled lanes are compared; the idle lane carries no promise
    task automatic rd_chk(input string nm, input logic [15:0] a, input logic [1:0] be,
        input logic [15:0] e);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        do_cmd(1'b0, a, 16'h0000, be);
        `CHK(nm, e & m, q & m);
    endtask

    task automatic do_reset(input logic [1:0] sel);
        int n;
        @(negedge mclk);
        arst_n = 1'b0;
        cfg_sel = sel;
        repeat (12) @(negedge mclk);
        arst_n = 1'b1;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        if (n == 400)
            error_cnt++;
    endtask

    task automatic pulse(input int g, input int b);
        @(negedge mclk);
        irq_event[g][b] = 1'b1;
        @(negedge mclk);
        irq_event[g][b] = 1'b0;
        repeat (5) @(negedge mclk);
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        arst_n = 1'b0;
        cfg_sel = IF_INTEL;
        cfg_sa = 6'h2d;
        cfg_pll = 11'h5a3;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr = 16'h0000;
        cmd_wdata = 16'h0000;
        cmd_be = 2'h0;
        irq_event = '0;
        for (int c = 0; c < NUM_CH; c++)
            alarm_status[c] = 8'h30 + c[7:0];
        do_reset(IF_INTEL);
        `CHK("vfe rst", 1'b1, variable_freq_enable);
        `CHK("t1 rst", 8'h00, ch_t1_mode);
        rd_chk("mask ab", 16'h0008, 2'b11, 16'hffff);
        rd_chk("mask cd", 16'h000a, 2'b11, 16'hffff);
        rd_chk("mask e", 16'h000c, 2'b11, 16'h00ff);
        rd_chk("isr rst", 16'h0012, 2'b01, 16'h0000);
        for (int c = 0; c < NUM_CH; c++)
            wr({c[7:0], CH_CTRL_OFF}, {15'h0000, c[0]}, 2'b01);
        `CHK("t1 flex", 8'haa, ch_t1_mode);
        for (int c = 0; c < NUM_CH; c++)
            rd_chk("ch word", {c[7:0], CH_CTRL_OFF}, 2'b11,
                {8'h30 + c[7:0], 7'h00, c[0]});
        alarm_status[5] = 8'hc5;
        rd_chk("stat live", 16'h0521, 2'b10, 16'hc500);
        wr(16'h0521, 16'h1100, 2'b10);
        rd_chk("stat ro", 16'h0521, 2'b10, 16'hc500);
        rd_chk("no channel", 16'h0820, 2'b11, 16'h0000);
        wr(16'h0000, 16'h0001, 2'b01);
        `CHK("t1 all", 8'hff, ch_t1_mode);
        `CHK("vfe off", 1'b0, variable_freq_enable);
        wr(16'h0000, 16'h0000, 2'b01);
        `CHK("e1 all", 8'h00, ch_t1_mode);
        wr(16'h0000, 16'h0010, 2'b01);
        `CHK("t1 back", 8'haa, ch_t1_mode);
        wr(16'h0008, 16'h1234, 2'b11);
        wr(16'h0009, 16'h5600, 2'b10);
        rd_chk("mask bytes", 16'h0008, 2'b11, 16'h5634);
        pulse(2, 3);
        `CHK("irq masked", 1'b0, irq_pending);
        rd_chk("isr set", 16'h0012, 2'b01, 16'h0008);
        rd_chk("isr clr", 16'h0012, 2'b01, 16'h0000);
        wr(16'h000a, 16'h00f7, 2'b01);
        pulse(2, 4);
        `CHK("irq other", 1'b0, irq_pending);
        pulse(2, 3);
        `CHK("irq on", 1'b1, irq_pending);
        rd_chk("isr both", 16'h0012, 2'b01, 16'h0018);
        repeat (5) @(negedge mclk);
        `CHK("irq off", 1'b0, irq_pending);
        // Both parallel modes get a write; serial straps must leave the bus deaf
        for (int k = 0; k < 4; k++)
        begin
            do_reset(k[1:0]);
            `CHK("mode", k[1:0], host_if_mode);
            `CHK("saddr", (k == 3) ? 6'h2d : 6'h00, serial_src_addr);
            `CHK("pll", (k > 1) ? 11'h5a3 : 11'h000, pll_config);
            if (k < 2)
            begin
                rd_chk("mask again", 16'h0008, 2'b11, 16'hffff);
                rd_chk("gcm again", 16'h0000, 2'b01, {8'h00, GCM_RST});
                wr(16'h000c, {8'h00, 8'h5a + k[7:0]}, 2'b01);
                rd_chk("mask mode", 16'h000c, 2'b01, {8'h00, 8'h5a + k[7:0]});
            end
            else
            begin
                rd_chk("serial deaf", 16'h0008, 2'b11, 16'h0000);
            end
            `CHK("mode held", k[1:0], host_if_mode);
        end
        report_and_stop();
    end
endmodule
